/* rtl/tdbw_top.sv */
// How it works
// RULE1 - One burst makes burst_length plus one window transfers; code 17 gives 18.
// RULE2 - burst_control holds length in bits 12:8, base offset in 4:0, reset zero.
// RULE3 - Base offset counts words from control_one: 0 control_one, 1 control_two, 2 slave.
// RULE4 - Window access goes to control_one address plus four times base plus pointer.
// RULE5 - The burst pointer advances on each window transfer, bounded by the length.
// RULE6 - Bits 7:5 of burst_control always read zero.
// RULE7 - Window has a 16-bit read-write field, reset zero; bits 31:16 reserved.
// RULE8 - Pointer starts at zero, steps per access, wraps after length plus one.
//
// Added by the designer: the strobed register port.
`include "tdbw_defs.svh"
`default_nettype none

module tdbw_top
  import tdbw_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  // Register port
  input  wire logic [`TDBW_ADDR_W-1:0] addr_in,
  input  wire logic [31:0]             wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [31:0]             rdata_out,
  // Redirected access to the timer register file
  output logic      [`TDBW_ADDR_W-1:0] tgt_addr_out,
  output logic      [15:0]             tgt_wdata_out,
  output logic                         tgt_wr_out,
  output logic                         tgt_rd_out,
  input  wire logic [15:0]             tgt_rdata_in,
  // Burst progress
  output logic                         burst_done_out
);

  tdbw_acc_t   acc;
  tdbw_field_t len_r;
  tdbw_field_t base_r;
  tdbw_word_t  win_data_r;
  tdbw_word_t  win_data_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        win_rd;
  logic        win_wr;
  logic        ctrl_wr;

  tdbw_ptr_if pif ();

  always_comb begin
    if (!rd_in && !wr_in) begin
      acc = TDBW_ACC_NONE;
    end else begin
      unique case (addr_in)
        `TDBW_CTRL_OFS: acc = TDBW_ACC_CTRL;
        `TDBW_WIN_OFS:  acc = TDBW_ACC_WIN;
        `TDBW_STAT_OFS: acc = TDBW_ACC_STAT;
        default:        acc = TDBW_ACC_UNMAPPED;
      endcase
    end
  end

  assign win_rd  = rd_in && (acc == TDBW_ACC_WIN);
  assign win_wr  = wr_in && (acc == TDBW_ACC_WIN);
  assign ctrl_wr = wr_in && (acc == TDBW_ACC_CTRL);

  // burst_control; reserved bits are simply not stored
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      len_r  <= `TDBW_FIELD_RST; // RULE2
      base_r <= `TDBW_FIELD_RST; // RULE2
    end else if (ctrl_wr) begin
      len_r  <= wdata_in[`TDBW_LEN_MSB:`TDBW_LEN_LSB]; // RULE2
      base_r <= wdata_in[`TDBW_BASE_MSB:`TDBW_BASE_LSB]; // RULE2
    end
  end

  // Reprogramming restarts the burst so it never resumes mid-sequence
  assign pif.len   = len_r; // RULE1
  assign pif.clear = ctrl_wr; // RULE8

  tdbw_ptr u_ptr (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .pif      (pif)
  );

  tdbw_redirect u_redirect (
    .base_in      (base_r),
    .win_rd_in    (win_rd),
    .win_wr_in    (win_wr),
    .ptr_in       (pif.ptr),
    .tgt_addr_out (tgt_addr_out),
    .tgt_rd_out   (tgt_rd_out),
    .tgt_wr_out   (tgt_wr_out),
    .step_out     (pif.step)
  );

  // Only the 16-bit field crosses the window
  assign tgt_wdata_out  = wdata_in[15:0]; // RULE7
  assign burst_done_out = pif.wrap; // RULE1

  // Last word passed through the window, either way
  always_comb begin
    win_data_nxt = win_data_r;
    if (win_wr) begin
      win_data_nxt = wdata_in[15:0]; // RULE7
    end else if (win_rd) begin
      win_data_nxt = tgt_rdata_in; // RULE7
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      win_data_r <= `TDBW_WIN_RST; // RULE7
    end else begin
      win_data_r <= win_data_nxt;
    end
  end

  // Read data stand one cycle and read zero otherwise
  always_comb begin
    rdata_nxt = `TDBW_RDATA_RST; // RULE6
    if (rd_in) begin
      unique case (acc)
        TDBW_ACC_CTRL: begin
          rdata_nxt[`TDBW_LEN_MSB:`TDBW_LEN_LSB]   = len_r; // RULE2
          rdata_nxt[`TDBW_BASE_MSB:`TDBW_BASE_LSB] = base_r;
        end
        TDBW_ACC_WIN: begin
          rdata_nxt[15:0] = tgt_rdata_in; // RULE4
        end
        TDBW_ACC_STAT: begin
          rdata_nxt[`TDBW_STAT_PTR_MSB:`TDBW_STAT_PTR_LSB] = pif.ptr;
          rdata_nxt[`TDBW_STAT_DAT_MSB:`TDBW_STAT_DAT_LSB] = win_data_r;
        end
        default: begin
          rdata_nxt = `TDBW_RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= `TDBW_RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_out = rdata_r;

endmodule

`default_nettype wire

/* rtl/tdbw_defs.svh */
`ifndef TDBW_DEFS_SVH
`define TDBW_DEFS_SVH

// Register byte offsets on the local register port
`define TDBW_ADDR_W        8
`define TDBW_CTRL_OFS      8'h48
`define TDBW_WIN_OFS       8'h4C
`define TDBW_STAT_OFS      8'h7C
// Byte address of control_one, origin of every redirected access
`define TDBW_CTRL_ONE_ADDR 8'h00

// burst_control field layout
`define TDBW_LEN_MSB       12
`define TDBW_LEN_LSB       8
`define TDBW_BASE_MSB      4
`define TDBW_BASE_LSB      0

// burst_status field layout
`define TDBW_STAT_PTR_MSB  4
`define TDBW_STAT_PTR_LSB  0
`define TDBW_STAT_DAT_MSB  31
`define TDBW_STAT_DAT_LSB  16

// Reset values
`define TDBW_FIELD_RST     5'h00
`define TDBW_WIN_RST       16'h0000
`define TDBW_RDATA_RST     32'h0000_0000

`endif

/* rtl/tdbw_pkg.sv */
`default_nettype none

package tdbw_pkg;

  typedef logic [4:0]  tdbw_field_t;
  typedef logic [15:0] tdbw_word_t;

  // Decoded target of one register-port access
  typedef enum logic [2:0] {
    TDBW_ACC_NONE,
    TDBW_ACC_CTRL,
    TDBW_ACC_WIN,
    TDBW_ACC_STAT,
    TDBW_ACC_UNMAPPED
  } tdbw_acc_t;

endpackage

`default_nettype wire

/* rtl/tdbw_ptr_if.sv */
`default_nettype none

interface tdbw_ptr_if;
  import tdbw_pkg::*;

  tdbw_field_t len;
  tdbw_field_t ptr;
  logic        clear;
  logic        step;
  logic        wrap;

  modport owner (
    input  len,
    input  clear,
    input  step,
    output ptr,
    output wrap
  );

  modport user (
    output len,
    output clear,
    output step,
    input  ptr,
    input  wrap
  );
endinterface

`default_nettype wire

/* rtl/tdbw_ptr.sv */
`include "tdbw_defs.svh"
`default_nettype none

module tdbw_ptr
  import tdbw_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Pointer control and state
  tdbw_ptr_if.owner pif
);

  tdbw_field_t ptr_r;
  tdbw_field_t ptr_nxt;
  logic        at_end;

  // Compare with >= so a length shortened mid-burst still wraps
  assign at_end   = (ptr_r >= pif.len);
  assign pif.wrap = pif.step && at_end; // RULE1

  always_comb begin
    ptr_nxt = ptr_r;
    if (pif.clear) begin
      ptr_nxt = `TDBW_FIELD_RST;
    end else if (pif.step) begin
      ptr_nxt = at_end ? `TDBW_FIELD_RST : ptr_r + 5'h01; // RULE8
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_r <= `TDBW_FIELD_RST; // RULE8
    end else begin
      ptr_r <= ptr_nxt; // RULE5
    end
  end

  assign pif.ptr = ptr_r;

endmodule

`default_nettype wire

/* rtl/tdbw_redirect.sv */
`include "tdbw_defs.svh"
`default_nettype none

module tdbw_redirect
  import tdbw_pkg::*;
(
  // Burst base and window strobes
  input  wire logic [4:0]              base_in,
  input  wire logic                    win_rd_in,
  input  wire logic                    win_wr_in,
  // Pointer state
  input  wire logic [4:0]              ptr_in,
  // Redirected access
  output logic      [`TDBW_ADDR_W-1:0] tgt_addr_out,
  output logic                         tgt_rd_out,
  output logic                         tgt_wr_out,
  output logic                         step_out
);

  logic [5:0] word_idx;

  // Six bits: largest base plus largest pointer must not wrap
  assign word_idx     = {1'b0, base_in} + {1'b0, ptr_in}; // RULE3
  assign tgt_addr_out = `TDBW_CTRL_ONE_ADDR + {word_idx, 2'b00}; // RULE4
  assign tgt_rd_out   = win_rd_in; // RULE4
  assign tgt_wr_out   = win_wr_in; // RULE4
  assign step_out     = win_rd_in | win_wr_in; // RULE5

endmodule

`default_nettype wire

/* bench/tdbw_properties.sv */
`default_nettype none
module tdbw_checker (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // Register port
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  // Redirected access
  input wire logic [7:0]  tgt_addr_out,
  input wire logic [15:0] tgt_wdata_out,
  input wire logic        tgt_wr_out,
  input wire logic        tgt_rd_out,
  input wire logic [15:0] tgt_rdata_in,
  input wire logic        burst_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       win;
  logic [4:0] len_r;
  logic [4:0] base_r;
  logic [4:0] cnt_r;
  assign win = (rd_in || wr_in) && addr_in == 8'h4C;
  // Shadow of length, base and pointer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      len_r <= 5'h00;
      base_r <= 5'h00;
      cnt_r <= 5'h00;
    end else if (wr_in && addr_in == 8'h48) begin
      len_r <= wdata_in[12:8];
      base_r <= wdata_in[4:0];
      cnt_r <= 5'h00;
    end else if (win) begin
      cnt_r <= (cnt_r >= len_r) ? 5'h00 : cnt_r + 5'h01;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  win_wr_a: assert property (wr_in && addr_in == 8'h4C
    |-> tgt_wr_out && tgt_wdata_out == wdata_in[15:0]) else $error("window write lost");
  win_rd_a: assert property (rd_in && addr_in == 8'h4C
    |-> tgt_rd_out ##1 rdata_out == {16'h0, $past(tgt_rdata_in)}) else $error("window read bad");
  no_tgt_a: assert property (!win |-> !tgt_rd_out && !tgt_wr_out) else $error("stray");
  ctrl_rd_a: assert property (rd_in && addr_in == 8'h48
    |=> rdata_out == {19'h0, len_r, 3'h0, base_r}) else $error("control read bad");
  tgt_addr_a: assert property (win |-> tgt_addr_out == 8'(4 * (base_r + cnt_r)))
    else $error("target address bad");
  burst_end_a: assert property (win |-> burst_done_out == (cnt_r >= len_r))
    else $error("burst end bad");
  done_win_a: assert property (burst_done_out |-> win) else $error("done alone");
  idle_rd_a: assert property (!rd_in |=> rdata_out == 32'h0) else $error("data stands");
  cover property (win && burst_done_out && len_r == 5'h11);
  cover property (rd_in && addr_in == 8'h48);
  cover property (wr_in && addr_in == 8'h4C);
endmodule
bind tdbw_top tdbw_checker tdbw_checker_i (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .tgt_addr_out, .tgt_wdata_out, .tgt_wr_out, .tgt_rd_out, .tgt_rdata_in,
  .burst_done_out);
`default_nettype wire

/* bench/tdbw_timer_file.sv */
`default_nettype none
module tdbw_timer_file (
  // Clock
  input  wire logic        clk_in,
  // Redirected access
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [64];
  // Distinct preset per word exposes a wrong target
  initial foreach (mem[i]) mem[i] = 16'hA500 + 16'(i);
  always @(posedge clk_in) begin
    if (wr_in) mem[addr_in[7:2]] <= wdata_in;
  end
  // Unselected bus shows inverted data, never a stale copy
  assign rdata_out = rd_in ? mem[addr_in[7:2]] : ~mem[addr_in[7:2]];
endmodule
`default_nettype wire

/* bench/tdbw_top_test.sv */
`default_nettype none
module tdbw_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [7:0]  t;
    logic        n;
  } tdbw_row_t;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [7:0]  tgt_addr_out;
  logic [15:0] tgt_wdata_out;
  logic [15:0] tgt_rdata_in;
  logic        tgt_wr_out;
  logic        tgt_rd_out;
  logic        burst_done_out;
  int          miscompares = 0;
  int          samples_checked = 0;
  // Length 2, base 1, reserved bits set on write
  tdbw_row_t   rows [11] = '{
    '{1'b0, 8'h48, 32'h0, 32'h0, 8'h00, 1'b0},
    '{1'b1, 8'h48, 32'h0000_02E1, 32'h0, 8'h00, 1'b0},
    '{1'b0, 8'h48, 32'h0, 32'h0000_0201, 8'h00, 1'b0},
    '{1'b1, 8'h4C, 32'hFFFF_1111, 32'h0, 8'h04, 1'b0},
    '{1'b1, 8'h4C, 32'h0000_2222, 32'h0, 8'h08, 1'b0},
    '{1'b1, 8'h4C, 32'h0000_3333, 32'h0, 8'h0C, 1'b1},
    '{1'b0, 8'h4C, 32'h0, 32'h0000_1111, 8'h04, 1'b0},
    '{1'b0, 8'h4C, 32'h0, 32'h0000_2222, 8'h08, 1'b0},
    '{1'b0, 8'h4C, 32'h0, 32'h0000_3333, 8'h0C, 1'b1},
    '{1'b0, 8'h7C, 32'h0, 32'h3333_0000, 8'h00, 1'b0},
    '{1'b0, 8'h20, 32'h0, 32'h0, 8'h00, 1'b0}};
  always #20 clk_in = ~clk_in;
  tdbw_top tdbw_top_i (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .tgt_addr_out, .tgt_wdata_out, .tgt_wr_out, .tgt_rd_out, .tgt_rdata_in, .burst_done_out);
  tdbw_timer_file tdbw_timer_file_i (.clk_in, .addr_in(tgt_addr_out), .wdata_in(tgt_wdata_out),
    .wr_in(tgt_wr_out), .rd_in(tgt_rd_out), .rdata_out(tgt_rdata_in));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Strobe stays up so back-to-back accesses never assign twice in one step
  task automatic acc(input tdbw_row_t r);
    wr_in <= r.w;
    rd_in <= !r.w;
    addr_in <= r.a;
    wdata_in <= r.d;
    #1;
    if (r.a == 8'h4C) begin
      chk("tgt_addr", {24'h0, tgt_addr_out}, {24'h0, r.t});
      chk("burst_done", {31'h0, burst_done_out}, {31'h0, r.n});
    end
    @(posedge clk_in);
    // Checked 1 ns after the edge so the next access can start at this edge
    if (!r.w) begin
      fork
        begin
          #1;
          chk("rdata", rdata_out, r.e);
        end
      join_none
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    foreach (rows[i]) acc(rows[i]);
    $display("table test done");
    // Length 17 burst, base 4, one extra read to see the wrap
    acc('{1'b1, 8'h48, 32'h0000_1104, 32'h0, 8'h00, 1'b0});
    for (int i = 0; i < 19; i++) begin
      acc('{1'b0, 8'h4C, 32'h0, 32'(16'hA504 + i % 18), 8'(4 * (4 + i % 18)), 1'(i % 18 == 17)});
    end
    $display("long burst test done");
    rd_in <= 1'b0;
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    acc(rows[0]);
    // Pointer left mid-burst must restart at zero after reset
    acc('{1'b0, 8'h4C, 32'h0, 32'h0000_A500, 8'h00, 1'b1});
    rd_in <= 1'b0;
    @(posedge clk_in);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
